//--- verilog/iopim_pkg.sv
// package: register map, image layout, carriers and helpers of the process image mapper
package iopim_pkg;

	// bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// input image word indices; analog words first, digital word last
	localparam logic [2:0] IMG_AIN1_MEAS = 3'h0; // single-channel module, measured voltage
	localparam logic [2:0] IMG_AIN1_REF = 3'h1; // single-channel module, reference voltage
	localparam logic [2:0] IMG_AIN2_CH1 = 3'h2; // two-channel module, channel 1
	localparam logic [2:0] IMG_AIN2_CH2 = 3'h3; // two-channel module, channel 2
	localparam logic [2:0] IMG_DIGITAL = 3'h4; // fault flags and input channel values
	localparam int IMG_WORDS = 5;

	// layout of the digital input word
	localparam int FAULT_LSB = 0; // fault flags, channel n at bit n-1
	localparam int IN_CH_LSB = 8; // combined module input channel values

	// register offsets; image words sit at offsets 0x00 to 0x04
	localparam logic [7:0] OFF_IMG_LAST = 8'h04;
	localparam logic [7:0] OFF_OUT_DIAG = 8'h10; // output image of the diagnostic output module
	localparam logic [7:0] OFF_OUT_DO16 = 8'h11; // output image of the 16-channel output module
	localparam logic [7:0] OFF_OUT_IO = 8'h12; // output image of the combined module
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h18; // sticky fault-raised bits, read only
	localparam logic [7:0] OFF_IRQ_CLEAR = 8'h19; // write one to clear, write only
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1a; // interrupt enables
	localparam logic [7:0] OFF_AIN1_CS = 8'h1b; // single-channel module control/status bytes
	localparam logic [7:0] OFF_AIN2_CS = 8'h1c; // two-channel module control/status bytes

	// reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// scan sequence over the input image words
	typedef enum logic [2:0] {
		SCAN_AIN1_MEAS = 3'b000,
		SCAN_AIN1_REF = 3'b001,
		SCAN_AIN2_CH1 = 3'b010,
		SCAN_AIN2_CH2 = 3'b011,
		SCAN_DIGITAL = 3'b100
	} iopim_scan_type;

	// one analog channel as the module delivers it
	typedef struct packed {
		logic [7:0] cs; // control/status byte, kept out of the image
		logic [15:0] value; // measured value
	} iopim_ain_type;

	// fault causes of the diagnostic output module, one bit per channel each
	typedef struct packed {
		logic [7:0] overload;
		logic [7:0] short_circuit;
		logic [7:0] broken_wire;
	} iopim_fault_src_type;

	// all analog channels together
	typedef struct packed {
		iopim_ain_type ain1_meas;
		iopim_ain_type ain1_ref;
		iopim_ain_type ain2_ch1;
		iopim_ain_type ain2_ch2;
	} iopim_ain_set_type;

	// address compare used by every register decode except the image range, which compares against OFF_IMG_LAST
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		reg_hit = (addr == off);
	endfunction : reg_hit

	// little-endian image word: low byte at the even byte, high byte after it
	function automatic logic [15:0] le_word(input logic [7:0] lo, input logic [7:0] hi);
		le_word = {hi, lo};
	endfunction : le_word

endpackage : iopim_pkg

//--- verilog/iopim_image_ram.sv
// small memory holding the input process image, with a registered read port
module iopim_image_ram
	import iopim_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 5,
	parameter int AW = 3
)(
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic [AW-1:0] rd_addr_i,
	input wire logic [WIDTH-1:0] alt_data_i,
	output logic [WIDTH-1:0] rd_data_o
);

	logic [WIDTH-1:0] mem [DEPTH]; // image words, no reset: the scan fills them
	logic [WIDTH-1:0] next_rd_data; // value to register on the read port

	// read port picks memory or the alternate word, so one flop serves all reads
	always_comb
	begin
		next_rd_data = alt_data_i;
		if (rd_en_i)
		begin
			next_rd_data = mem[rd_addr_i];
		end
	end

	// write port, unmasked by reset: stale words are simply overwritten
	always_ff @(posedge sys_clk_i)
	begin
		if (wr_en_i)
		begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	// registered read data
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			rd_data_o <= '0;
		end
		else
		begin
			rd_data_o <= next_rd_data;
		end
	end

endmodule : iopim_image_ram

//--- verilog/iopim_mapper.sv
// top of the process image mapper: output image registers, input image scan, fault interrupt
//
// The register addresses and the plain strobed port are this design's own decisions.
module iopim_mapper
	import iopim_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	output logic irq_o,
	input wire iopim_fault_src_type fault_src_i,
	input wire logic [7:0] input_channel_value_i,
	input wire iopim_ain_set_type ain_i,
	output logic [7:0] diag_out_o,
	output logic [15:0] do16_out_o,
	output logic [7:0] io_out_o,
	output logic [7:0] fault_flag_o
);

	// pin synchronisers, two stages each; only stage two is read
	iopim_fault_src_type fault_src_s1;
	iopim_fault_src_type fault_src_s2;
	logic [7:0] in_ch_s1;
	logic [7:0] in_ch_s2;
	iopim_ain_set_type ain_s1; // analog words are not coherent across bits while changing
	iopim_ain_set_type ain_s2;

	// control state
	iopim_scan_type scan; // image word being refreshed
	iopim_scan_type next_scan;
	logic [7:0] fault_prev; // fault flags one cycle ago, for edge detection
	logic [7:0] irq_status; // sticky fault-raised bits
	logic [7:0] next_irq_status;
	logic [7:0] irq_enable;
	logic [7:0] next_irq_enable;
	logic [7:0] next_diag_out;
	logic [15:0] next_do16_out;
	logic [7:0] next_io_out;
	logic next_irq;

	// combinational helpers
	logic [7:0] fault_now; // current fault level per channel
	logic [7:0] fault_rise; // newly raised faults
	logic [15:0] img_word; // word written to the image this cycle
	logic [2:0] img_addr;
	logic img_rd; // read hits the image memory
	logic [15:0] reg_rdata; // read value of the plain registers
	// image address width follows the word count, so a longer image widens the decode
	localparam int IMG_AW = $clog2(IMG_WORDS);

	// synchronise every pin before use
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			fault_src_s1 <= '0;
			fault_src_s2 <= '0;
			in_ch_s1 <= RST_BYTE;
			in_ch_s2 <= RST_BYTE;
			ain_s1 <= '0;
			ain_s2 <= '0;
		end
		else
		begin
			fault_src_s1 <= fault_src_i;
			fault_src_s2 <= fault_src_s1;
			in_ch_s1 <= input_channel_value_i;
			in_ch_s2 <= in_ch_s1;
			ain_s1 <= ain_i;
			ain_s2 <= ain_s1;
		end
	end

	// any of the three causes raises a channel's flag, and it drops with the cause
	always_comb
	begin
		fault_now = fault_src_s2.overload | fault_src_s2.short_circuit | fault_src_s2.broken_wire;
		fault_rise = fault_now & ~fault_prev;
	end

	// scan walks the image words in a fixed round, analog first
	always_comb
	begin
		next_scan = SCAN_AIN1_MEAS;
		img_word = RST_WORD;
		img_addr = IMG_AIN1_MEAS;
		case (scan)
			SCAN_AIN1_MEAS:
			begin
				// measured voltage at word 0; status byte stays out
				img_word = le_word(ain_s2.ain1_meas.value[7:0], ain_s2.ain1_meas.value[15:8]);
				img_addr = IMG_AIN1_MEAS;
				next_scan = SCAN_AIN1_REF;
			end
			SCAN_AIN1_REF:
			begin
				// reference voltage at word 1
				img_word = le_word(ain_s2.ain1_ref.value[7:0], ain_s2.ain1_ref.value[15:8]);
				img_addr = IMG_AIN1_REF;
				next_scan = SCAN_AIN2_CH1;
			end
			SCAN_AIN2_CH1:
			begin
				// two-channel module starts with channel 1
				img_word = le_word(ain_s2.ain2_ch1.value[7:0], ain_s2.ain2_ch1.value[15:8]);
				img_addr = IMG_AIN2_CH1;
				next_scan = SCAN_AIN2_CH2;
			end
			SCAN_AIN2_CH2:
			begin
				img_word = le_word(ain_s2.ain2_ch2.value[7:0], ain_s2.ain2_ch2.value[15:8]);
				img_addr = IMG_AIN2_CH2;
				next_scan = SCAN_DIGITAL;
			end
			SCAN_DIGITAL:
			begin
				// digital data after all analog words
				img_word = RST_WORD;
				img_word[FAULT_LSB +: 8] = fault_now;
				img_word[IN_CH_LSB +: 8] = in_ch_s2;
				img_addr = IMG_DIGITAL;
				next_scan = SCAN_AIN1_MEAS;
			end
			default:
			begin
				// unknown code restarts the round
				next_scan = SCAN_AIN1_MEAS;
			end
		endcase
	end

	// image memory: scan writes, bus reads; plain registers go through its read flop
	iopim_image_ram #(
		.WIDTH(DATA_W),
		.DEPTH(IMG_WORDS),
		.AW(IMG_AW)
	) u_image_ram (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.wr_en_i(1'b1),
		.wr_addr_i(img_addr),
		.wr_data_i(img_word),
		.rd_en_i(img_rd),
		.rd_addr_i(addr_i[IMG_AW-1:0]),
		.alt_data_i(reg_rdata),
		.rd_data_o(rdata_o)
	);

	// read decode; unmapped and write-only offsets read zero, idle cycles give zero
	always_comb
	begin
		img_rd = rd_i && (addr_i <= OFF_IMG_LAST);
		reg_rdata = RST_WORD;
		if (rd_i)
		begin
			if (reg_hit(addr_i, OFF_OUT_DIAG))
			begin
				reg_rdata[7:0] = diag_out_o;
			end
			else if (reg_hit(addr_i, OFF_OUT_DO16))
			begin
				reg_rdata = do16_out_o;
			end
			else if (reg_hit(addr_i, OFF_OUT_IO))
			begin
				reg_rdata[7:0] = io_out_o;
			end
			else if (reg_hit(addr_i, OFF_IRQ_STATUS))
			begin
				reg_rdata[7:0] = irq_status;
			end
			else if (reg_hit(addr_i, OFF_IRQ_ENABLE))
			begin
				reg_rdata[7:0] = irq_enable;
			end
			else if (reg_hit(addr_i, OFF_AIN1_CS))
			begin
				// status bytes only reachable here, for configuration software
				reg_rdata = {ain_s2.ain1_ref.cs, ain_s2.ain1_meas.cs};
			end
			else if (reg_hit(addr_i, OFF_AIN2_CS))
			begin
				reg_rdata = {ain_s2.ain2_ch2.cs, ain_s2.ain2_ch1.cs};
			end
			else
			begin
				reg_rdata = RST_WORD;
			end
		end
	end

	// output image registers, written from the bus only
	always_comb
	begin
		next_diag_out = diag_out_o;
		next_do16_out = do16_out_o;
		next_io_out = io_out_o;
		// a write to any other offset leaves every output as it was
		if (wr_i)
		begin
			if (reg_hit(addr_i, OFF_OUT_DIAG))
			begin
				next_diag_out = wdata_i[7:0];
			end
			if (reg_hit(addr_i, OFF_OUT_DO16))
			begin
				next_do16_out = wdata_i;
			end
			if (reg_hit(addr_i, OFF_OUT_IO))
			begin
				next_io_out = wdata_i[7:0];
			end
		end
	end

	// interrupt enables and sticky status
	always_comb
	begin
		next_irq_enable = irq_enable;
		next_irq_status = irq_status;
		// clear is write-one; zero bits leave their status alone
		if (wr_i)
		begin
			if (reg_hit(addr_i, OFF_IRQ_ENABLE))
			begin
				next_irq_enable = wdata_i[7:0];
			end
			if (reg_hit(addr_i, OFF_IRQ_CLEAR))
			begin
				next_irq_status = irq_status & ~wdata_i[7:0];
			end
		end
		// a fault rising in the clearing cycle is kept, so no event is lost to a late clear
		next_irq_status = next_irq_status | fault_rise;
		next_irq = |(next_irq_status & next_irq_enable);
	end

	// scan position and fault level; fault_prev feeds the rising-edge detector
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			scan <= SCAN_AIN1_MEAS;
			fault_prev <= RST_BYTE;
			fault_flag_o <= RST_BYTE;
		end
		else
		begin
			// both copies hold the same level, one for the edge detector, one for the pins
			scan <= next_scan;
			fault_prev <= fault_now;
			fault_flag_o <= fault_now;
		end
	end

	// output image registers; a write shows on the pins one cycle after its strobe
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			diag_out_o <= RST_BYTE;
			do16_out_o <= RST_WORD;
			io_out_o <= RST_BYTE;
		end
		else
		begin
			diag_out_o <= next_diag_out;
			do16_out_o <= next_do16_out;
			io_out_o <= next_io_out;
		end
	end

	// interrupt registers; irq_o comes from the next state so it rises with its status bit
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			irq_status <= RST_BYTE;
			irq_enable <= RST_BYTE;
			irq_o <= 1'b0;
		end
		else
		begin
			// status and enable share one layout: bit n-1 is channel n
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			irq_o <= next_irq;
		end
	end

endmodule : iopim_mapper

//--- bench/iopim_mapper_props.sv
// checker watching the ports of the process image mapper
module iopim_mapper_props
	import iopim_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic irq_o,
	input wire iopim_fault_src_type fault_src_i,
	input wire logic [7:0] input_channel_value_i,
	input wire iopim_ain_set_type ain_i,
	input wire logic [7:0] diag_out_o,
	input wire logic [15:0] do16_out_o,
	input wire logic [7:0] io_out_o,
	input wire logic [7:0] fault_flag_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [127:0] pins; // all field pins side by side
	logic [127:0] last; // pins one cycle ago
	logic [3:0] quiet; // cycles the pins have not moved
	logic [3:0] next_quiet;
	logic [7:0] cause; // any fault cause per channel
	assign pins = {fault_src_i, input_channel_value_i, ain_i};
	assign cause = fault_src_i.overload | fault_src_i.short_circuit | fault_src_i.broken_wire;
	// saturating count, so the sync chain and image scan have settled
	always_comb
	begin
		next_quiet = quiet;
		if (!reset_n_i || pins != last)
			next_quiet = 4'h0;
		else if (quiet != 4'hf)
			next_quiet = quiet + 4'h1;
	end
	// register the helper state
	always_ff @(posedge sys_clk_i)
	begin
		last <= pins;
		quiet <= next_quiet;
	end
	a_diag_write: assert property (wr_i && addr_i == OFF_OUT_DIAG |=> diag_out_o == $past(wdata_i[7:0]))
		else $error("diag outputs differ from written word");
	a_do16_write: assert property (wr_i && addr_i == OFF_OUT_DO16 |=> do16_out_o == $past(wdata_i))
		else $error("16-channel outputs differ from written word");
	a_io_write: assert property (wr_i && addr_i == OFF_OUT_IO |=> io_out_o == $past(wdata_i[7:0]))
		else $error("combined outputs differ from written word");
	a_flag_follows: assert property (quiet >= 4'h4 && pins == last |-> fault_flag_o == cause)
		else $error("fault flags differ from causes");
	a_digital_word: assert property (rd_i && addr_i == 8'h04 && quiet >= 4'hc
		|=> rdata_o == {$past(input_channel_value_i), $past(fault_flag_o)})
		else $error("digital image word wrong");
	a_single_meas: assert property (rd_i && addr_i == 8'h00 && quiet >= 4'hc
		|=> rdata_o == $past(ain_i.ain1_meas.value))
		else $error("measured voltage word wrong");
	a_dual_second: assert property (rd_i && addr_i == 8'h03 && quiet >= 4'hc
		|=> rdata_o == $past(ain_i.ain2_ch2.value))
		else $error("second channel word wrong");
	a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data outside its cycle");
	c_fault: cover property (cause != 8'h00);
	c_image: cover property (rd_i && addr_i == 8'h04 && quiet >= 4'hc);
	c_irq: cover property ($rose(irq_o));
endmodule : iopim_mapper_props

bind iopim_mapper iopim_mapper_props iopim_mapper_props_inst (.sys_clk_i, .reset_n_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .rdata_o, .irq_o, .fault_src_i, .input_channel_value_i, .ain_i, .diag_out_o,
	.do16_out_o, .io_out_o, .fault_flag_o);

//--- bench/iopim_field_model.sv
// behavioural model of the attached output, input and analog modules
module iopim_field_model
	import iopim_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic [7:0] diag_out_i,
	input wire logic [7:0] io_out_i,
	input wire logic [7:0] heavy_i, // load draws too much current
	input wire logic [7:0] shorted_i, // load shorted
	input wire logic [7:0] open_i, // wire cut
	input wire logic [15:0] meas_i, // analog base value
	output iopim_fault_src_type fault_src_o,
	output logic [7:0] input_channel_value_o,
	output iopim_ain_set_type ain_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// pins move at most once per clock; cs bytes are nonzero so a leak shows up
	always_ff @(posedge sys_clk_i)
	begin
		fault_src_o.overload <= diag_out_i & heavy_i; // only a driven output overloads
		fault_src_o.short_circuit <= diag_out_i & shorted_i;
		fault_src_o.broken_wire <= open_i;
		input_channel_value_o <= io_out_i; // loop back, inputs wired to outputs
		ain_o.ain1_meas <= {8'ha5, meas_i};
		ain_o.ain1_ref <= {8'h5a, ~meas_i};
		ain_o.ain2_ch1 <= {8'hc3, meas_i[7:0], meas_i[15:8]};
		ain_o.ain2_ch2 <= {8'h3c, meas_i ^ 16'h00ff};
	end
endmodule : iopim_field_model

//--- bench/test_io_process_image_mapper.sv
// self-checking bench for the process image mapper
module test_io_process_image_mapper
	import iopim_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] addr; logic [15:0] data; logic [15:0] exp;} iopim_row_type;
	logic sys_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [15:0] rdata_o, do16_out_o, got;
	logic irq_o;
	logic [7:0] diag_out_o, io_out_o, fault_flag_o, in_val;
	logic [7:0] heavy = 8'h00, shorted = 8'h00, open_w = 8'h00, f;
	logic [15:0] meas = 16'h0000;
	iopim_fault_src_type fault_src;
	iopim_ain_set_type ain;
	int failures = 0;
	int check_count = 0;
	// upper byte of 8-bit registers must be dropped
	iopim_row_type rows [6] = '{'{OFF_OUT_DIAG, 16'hff81, 16'h0081}, '{OFF_OUT_DIAG, 16'h007e, 16'h007e},
		'{OFF_OUT_DO16, 16'h8001, 16'h8001}, '{OFF_OUT_DO16, 16'h7ffe, 16'h7ffe},
		'{OFF_OUT_IO, 16'h33a5, 16'h00a5}, '{OFF_OUT_IO, 16'h005a, 16'h005a}};
	always #50 sys_clk_i = ~sys_clk_i;
	iopim_mapper iopim_mapper_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.fault_src_i(fault_src), .input_channel_value_i(in_val), .ain_i(ain), .diag_out_o(diag_out_o),
		.do16_out_o(do16_out_o), .io_out_o(io_out_o), .fault_flag_o(fault_flag_o));
	iopim_field_model iopim_field_model_inst (.sys_clk_i(sys_clk_i), .diag_out_i(diag_out_o),
		.io_out_i(io_out_o), .heavy_i(heavy), .shorted_i(shorted), .open_i(open_w), .meas_i(meas),
		.fault_src_o(fault_src), .input_channel_value_o(in_val), .ain_o(ain));
	// compare and count
	task automatic check(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check
	// one-cycle write; #1 lets the register update land before anyone looks
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr
	// one-cycle read; data stands only in the following cycle
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		check(rdata_o, e);
	endtask : rdchk
	// verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	// watchdog, far beyond the roughly 930 cycles the tests need
	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		failures++;
		complete_run();
	end
	// main sequence
	initial
	begin
		repeat (12) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		#1;
		check({do16_out_o, diag_out_o, io_out_o, fault_flag_o} == 40'h0, 16'h0001);
		rdchk(OFF_IRQ_STATUS, 16'h0000);
		// output images, written then read back
		for (int r = 0; r < 6; r++)
		begin
			wr(rows[r].addr, rows[r].data);
			got = (rows[r].addr == OFF_OUT_DO16) ? do16_out_o :
				(rows[r].addr == OFF_OUT_IO) ? {8'h00, io_out_o} : {8'h00, diag_out_o};
			check(got, rows[r].exp);
			rdchk(rows[r].addr, rows[r].exp);
		end
		// every cause on every channel, set then gone
		wr(OFF_OUT_DIAG, 16'h00ff);
		for (int i = 0; i < 24; i++)
		begin
			f = 8'h01 << (i % 8);
			heavy <= (i < 8) ? f : 8'h00;
			shorted <= (i >= 8 && i < 16) ? f : 8'h00;
			open_w <= (i >= 16) ? f : 8'h00;
			repeat (16) @(posedge sys_clk_i);
			check({8'h00, fault_flag_o}, {8'h00, f});
			rdchk(8'h04, {8'h5a, f});
			heavy <= 8'h00;
			shorted <= 8'h00;
			open_w <= 8'h00;
			repeat (16) @(posedge sys_clk_i);
			check({8'h00, fault_flag_o}, 16'h0000);
		end
		// sticky status, enable, clear and mask
		rdchk(OFF_IRQ_STATUS, 16'h00ff);
		check({15'h0000, irq_o}, 16'h0000);
		wr(OFF_IRQ_ENABLE, 16'h0004);
		rdchk(OFF_IRQ_ENABLE, 16'h0004);
		check({15'h0000, irq_o}, 16'h0001);
		wr(OFF_IRQ_CLEAR, 16'h00ff);
		rdchk(OFF_IRQ_STATUS, 16'h0000);
		rdchk(OFF_IRQ_CLEAR, 16'h0000);
		check({15'h0000, irq_o}, 16'h0000);
		open_w <= 8'h24;
		repeat (8) @(posedge sys_clk_i);
		check({15'h0000, irq_o}, 16'h0001);
		rdchk(OFF_IRQ_STATUS, 16'h0024);
		wr(OFF_IRQ_CLEAR, 16'h0004);
		rdchk(OFF_IRQ_STATUS, 16'h0020);
		check({15'h0000, irq_o}, 16'h0000);
		open_w <= 8'h00;
		// a fault rising in the very cycle of its clear: the set wins
		@(posedge sys_clk_i);
		open_w <= 8'h04;
		repeat (2) @(posedge sys_clk_i);
		wr(OFF_IRQ_CLEAR, 16'h0004);
		rdchk(OFF_IRQ_STATUS, 16'h0024);
		check({15'h0000, irq_o}, 16'h0001);
		open_w <= 8'h00;
		// analog words and their hidden status bytes
		meas <= 16'h12f0;
		repeat (16) @(posedge sys_clk_i);
		rdchk(8'h00, 16'h12f0);
		rdchk(8'h01, 16'hed0f);
		rdchk(8'h02, 16'hf012);
		rdchk(8'h03, 16'h120f);
		rdchk(OFF_AIN1_CS, 16'h5aa5);
		rdchk(OFF_AIN2_CS, 16'h3cc3);
		// unmapped places
		wr(8'h13, 16'hffff);
		rdchk(8'h13, 16'h0000);
		rdchk(8'h05, 16'h0000);
		check(do16_out_o, 16'h7ffe);
		// second reset in mid-run
		@(posedge sys_clk_i);
		reset_n_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		#1;
		check({do16_out_o, diag_out_o, io_out_o} == 32'h0, 16'h0001);
		rdchk(OFF_OUT_DO16, 16'h0000);
		complete_run();
	end
endmodule : test_io_process_image_mapper
